// [include/fsw_pkg.sv]
// shared constants and types of the flash status and write-protect block
`default_nettype none
package fsw_pkg;
    // opcodes
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_QUAD_READ = 8'hEB;
    localparam logic [7:0] OP_QUAD_WREAD = 8'hE7;
    localparam logic [7:0] OP_QUAD_PROG = 8'h38;
    // status byte field positions
    localparam int BIT_BUSY = 0;
    localparam int BIT_LATCH = 1;
    localparam int BIT_PL_LO = 2;
    localparam int BIT_QPE = 6;
    localparam int BIT_LOCK = 7;
    localparam logic [7:0] NV_WRITE_MASK = 8'hFC;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int STATUS_WRITE_TIME_NS = 40000;
    localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int TW_W = 24;
    // frame decoder states
    typedef enum logic [1:0] {FR_IDLE, FR_OPCODE, FR_DATA, FR_READOUT} fsw_frame_t;
endpackage : fsw_pkg
`default_nettype wire

// [include/fsw_if.sv]
// link between frame decoder and status register core
`default_nettype none
interface fsw_if;
    logic cmd_valid;
    logic [7:0] cmd_op;
    logic [7:0] cmd_data;
    logic cmd_has_data;
    logic frame_ok;
    modport dec (output cmd_valid, output cmd_op, output cmd_data, output cmd_has_data,
        output frame_ok);
    modport core (input cmd_valid, input cmd_op, input cmd_data, input cmd_has_data,
        input frame_ok);
endinterface : fsw_if
`default_nettype wire

// [design/fsw_frame_dec.sv]
// deserialiser of command frames, single-line or quad
`default_nettype none
module fsw_frame_dec (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // link
    input wire logic i_cs_n,
    input wire logic i_sclk_rise,
    input wire logic [3:0] i_sio,
    input wire logic i_quad_cmd,
    // decoded frame
    fsw_if.dec cmd
);
    typedef struct packed {
        logic cs_q;
        logic [7:0] shift;
        logic [3:0] bits;
        logic [7:0] op;
        logic [7:0] data;
        logic has_op;
        logic has_data;
        logic valid;
        logic ok;
    } fsw_dec_st_t;
    fsw_dec_st_t st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        st_next.valid = 1'b0;
        st_next.cs_q = i_cs_n;
        if (!i_cs_n && i_sclk_rise) begin
            if (i_quad_cmd) begin
                st_next.shift = {st_reg.shift[3:0], i_sio};
                st_next.bits = st_reg.bits + 4'h4;
            end else begin
                // upper lines ignored in single-line mode
                st_next.shift = {st_reg.shift[6:0], i_sio[0]};
                st_next.bits = st_reg.bits + 4'h1;
            end
            if (st_next.bits == 4'h8) begin
                st_next.bits = 4'h0;
                if (!st_reg.has_op) begin
                    st_next.op = st_next.shift;
                    st_next.has_op = 1'b1;
                end else if (!st_reg.has_data) begin
                    st_next.data = st_next.shift;
                    st_next.has_data = 1'b1;
                end else begin
                    st_next.ok = 1'b0;
                end
            end
        end
        if (i_cs_n && !st_reg.cs_q) begin
            st_next.valid = st_reg.has_op;
            st_next.ok = st_reg.ok && (st_reg.bits == 4'h0);
        end
        // frame contents stand through the valid cycle, cleared one cycle later
        if (i_cs_n && st_reg.cs_q) begin
            st_next.bits = 4'h0;
            st_next.has_op = 1'b0;
            st_next.has_data = 1'b0;
            st_next.ok = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '{cs_q: 1'b1, ok: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign cmd.cmd_valid = st_reg.valid;
    assign cmd.cmd_op = st_reg.op;
    assign cmd.cmd_data = st_reg.data;
    assign cmd.cmd_has_data = st_reg.has_data;
    assign cmd.frame_ok = st_reg.ok;
endmodule : fsw_frame_dec
`default_nettype wire

// [design/fsw_tw_timer.sv]
// self-timed status write cycle counter
`default_nettype none
module fsw_tw_timer (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // control
    input wire logic i_start,
    output logic o_busy,
    output logic o_done
);
    typedef struct packed {
        logic [fsw_pkg::TW_W-1:0] cnt;
        logic busy;
        logic done;
    } fsw_tw_st_t;
    fsw_tw_st_t st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (i_start && !st_reg.busy) begin
            st_next.busy = 1'b1;
            st_next.cnt = fsw_pkg::TW_W'(fsw_pkg::STATUS_WRITE_CYCLES - 1);
        end else if (st_reg.busy) begin
            if (st_reg.cnt == '0) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt - fsw_pkg::TW_W'(1);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_busy = st_reg.busy;
    assign o_done = st_reg.done;
endmodule : fsw_tw_timer
`default_nettype wire

// [design/fsw_status_core.sv]
// status byte and write-protect logic of a serial flash
`default_nettype none
module fsw_status_core (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // serial link, sampled on i_sclk_rise, output shifted on i_sclk_fall
    input wire logic i_cs_n,
    input wire logic i_sclk_rise,
    input wire logic i_sclk_fall,
    input wire logic [3:0] i_sio,
    input wire logic i_write_protect_pin,
    input wire logic i_quad_command_mode,
    // array engine handshake
    input wire logic i_array_req,
    input wire logic i_array_chip_erase,
    input wire logic i_array_protected,
    input wire logic i_array_done,
    output logic o_array_go,
    // serial output, active-low enables
    output logic [3:0] o_sio,
    output logic [3:0] o_sio_oe_n,
    // status
    output logic [7:0] o_flash_status_byte,
    output logic o_hardware_lock_mode
);
    fsw_if cmd ();
    logic tw_busy;
    logic tw_done;
    logic tw_start;

    fsw_frame_dec u_dec (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_cs_n(i_cs_n),
        .i_sclk_rise(i_sclk_rise),
        .i_sio(i_sio),
        .i_quad_cmd(i_quad_command_mode),
        .cmd(cmd)
    );

    fsw_tw_timer u_tw (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_start(tw_start),
        .o_busy(tw_busy),
        .o_done(tw_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] status;
        logic array_busy;
        logic array_go;
        logic hw_lock;
        logic reading;
        logic [7:0] live_shift;
        logic [3:0] out_bits;
        logic [7:0] shift;
        logic [3:0] out;
        logic [3:0] oe_n;
        logic tw_start;
    } fsw_core_st_t;
    fsw_core_st_t st_reg, st_next;

    function automatic logic is_quad_op(input logic [7:0] op);
        is_quad_op = (op == fsw_pkg::OP_QUAD_READ) || (op == fsw_pkg::OP_QUAD_WREAD)
            || (op == fsw_pkg::OP_QUAD_PROG);
    endfunction : is_quad_op

    logic lock_bit;
    logic hw_lock_now;
    logic [7:0] live_status;
    logic end_ok;
    logic [7:0] opcode_now;
    logic op_refused;

    always_comb begin
        lock_bit = st_reg.status[fsw_pkg::BIT_LOCK];
        hw_lock_now = lock_bit && !i_write_protect_pin && !i_quad_command_mode
            && !st_reg.status[fsw_pkg::BIT_QPE];
        live_status = st_reg.status;
        live_status[fsw_pkg::BIT_BUSY] = tw_busy || st_reg.array_busy;
        end_ok = cmd.cmd_valid && cmd.frame_ok;
        opcode_now = cmd.cmd_op;
        // single-line quad opcodes dead without quad enable; quad mode ignores it
        op_refused = !i_quad_command_mode && is_quad_op(opcode_now)
            && !st_reg.status[fsw_pkg::BIT_QPE];
    end

    always_comb begin
        st_next = st_reg;
        st_next.array_go = 1'b0;
        st_next.tw_start = 1'b0;
        st_next.hw_lock = hw_lock_now;
        // finish of status write cycle
        if (tw_done) begin
            st_next.status[fsw_pkg::BIT_LATCH] = 1'b0;
        end
        // framed single-opcode commands
        if (end_ok && !cmd.cmd_has_data && !op_refused) begin
            if (opcode_now == fsw_pkg::OP_LATCH_SET && !tw_busy) begin
                st_next.status[fsw_pkg::BIT_LATCH] = 1'b1;
            end
            if (opcode_now == fsw_pkg::OP_LATCH_CLEAR && !tw_busy) begin
                st_next.status[fsw_pkg::BIT_LATCH] = 1'b0;
            end
        end
        // status write: latch set, not locked, not busy, exact byte framing
        if (end_ok && cmd.cmd_has_data && opcode_now == fsw_pkg::OP_STATUS_WRITE
                && st_reg.status[fsw_pkg::BIT_LATCH] && !hw_lock_now
                && !tw_busy && !st_reg.array_busy) begin
            st_next.status = (cmd.cmd_data & fsw_pkg::NV_WRITE_MASK)
                | (st_reg.status & ~fsw_pkg::NV_WRITE_MASK);
            st_next.tw_start = 1'b1;
        end
        // array program and erase requests
        if (i_array_req && !st_reg.array_busy && !tw_busy) begin
            if (!st_reg.status[fsw_pkg::BIT_LATCH]) begin
                st_next.array_go = 1'b0;
            end else if (i_array_protected || (i_array_chip_erase
                    && st_reg.status[5:fsw_pkg::BIT_PL_LO] != 4'h0)) begin
                st_next.status[fsw_pkg::BIT_LATCH] = 1'b0;
            end else begin
                st_next.array_go = 1'b1;
                st_next.array_busy = 1'b1;
            end
        end
        if (st_reg.array_busy && i_array_done) begin
            st_next.array_busy = 1'b0;
            st_next.status[fsw_pkg::BIT_LATCH] = 1'b0;
        end
        ////////////////////////////////////////////////////////////////////////
        // status readout on the serial output
        if (i_cs_n) begin
            st_next.reading = 1'b0;
            st_next.oe_n = 4'hF;
            st_next.out_bits = 4'h0;
        end else if (!st_reg.reading && i_sclk_rise && st_reg.out_bits != 4'hF) begin
            // counting stops after any other opcode until chip select rises
            // opcode seen complete by tracking on the fly
            if (i_quad_command_mode) begin
                st_next.live_shift = {st_reg.live_shift[3:0], i_sio};
                st_next.out_bits = st_reg.out_bits + 4'h4;
            end else begin
                st_next.live_shift = {st_reg.live_shift[6:0], i_sio[0]};
                st_next.out_bits = st_reg.out_bits + 4'h1;
            end
            if (st_next.out_bits == 4'h8) begin
                st_next.out_bits = 4'h0;
                st_next.reading = (st_next.live_shift == fsw_pkg::OP_STATUS_READ);
                st_next.out_bits = 4'hF;
            end
        end else if (st_reg.reading && i_sclk_fall) begin
            if (st_reg.out_bits == 4'hF || st_reg.out_bits == 4'h0) begin
                st_next.shift = live_status;
            end
            if (i_quad_command_mode) begin
                st_next.out = (st_reg.out_bits == 4'h1) ? st_reg.shift[3:0]
                    : live_status[7:4];
                if (st_reg.out_bits == 4'h1) begin
                    st_next.out_bits = 4'h0;
                end else begin
                    st_next.shift = live_status;
                    st_next.out_bits = 4'h1;
                end
                st_next.oe_n = 4'h0;
            end else begin
                if (st_reg.out_bits == 4'hF || st_reg.out_bits == 4'h0) begin
                    st_next.out = {2'h0, live_status[7], 1'b0};
                    st_next.shift = {live_status[6:0], 1'b0};
                    st_next.out_bits = 4'h7;
                end else begin
                    st_next.out = {2'h0, st_reg.shift[7], 1'b0};
                    st_next.shift = {st_reg.shift[6:0], 1'b0};
                    st_next.out_bits = st_reg.out_bits - 4'h1;
                end
                st_next.oe_n = 4'hD;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '{status: fsw_pkg::STATUS_RESET, oe_n: 4'hF, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign tw_start = st_reg.tw_start;

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops
    logic [7:0] status_out_reg;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            status_out_reg <= fsw_pkg::STATUS_RESET;
        end else begin
            status_out_reg <= live_status;
        end
    end
    assign o_flash_status_byte = status_out_reg;
    assign o_hardware_lock_mode = st_reg.hw_lock;
    assign o_array_go = st_reg.array_go;
    assign o_sio = st_reg.out;
    assign o_sio_oe_n = st_reg.oe_n;

    ////////////////////////////////////////////////////////////////////////////
    a_write_latch_set: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (cmd.cmd_valid && cmd.frame_ok && !cmd.cmd_has_data && !tw_busy && !tw_done
        && cmd.cmd_op == fsw_pkg::OP_LATCH_SET && !i_array_req && !st_reg.array_busy)
        |=> st_reg.status[fsw_pkg::BIT_LATCH]) else $error("latch not set");
    a_latch_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (cmd.cmd_valid && cmd.frame_ok && !cmd.cmd_has_data && !tw_busy
        && cmd.cmd_op == fsw_pkg::OP_LATCH_CLEAR)
        |=> !st_reg.status[fsw_pkg::BIT_LATCH]) else $error("latch not cleared");
    a_tw_clears_latch: assert property (@(posedge i_clk) disable iff (!i_rstn)
        tw_done |=> !st_reg.status[fsw_pkg::BIT_LATCH]) else $error("tw kept latch");
    a_low_bits_kept: assert property (@(posedge i_clk) disable iff (!i_rstn)
        st_reg.tw_start |-> st_reg.status[1] == $past(st_reg.status[1]))
        else $error("low bits written");
    a_lock_blocks_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
        hw_lock_now |=> !st_reg.tw_start) else $error("write in lock");
    a_busy_during_tw: assert property (@(posedge i_clk) disable iff (!i_rstn)
        st_reg.tw_start |=> ##1 live_status[fsw_pkg::BIT_BUSY][*4])
        else $error("busy low in tw");
    a_latch_gates_go: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_array_req && !st_reg.status[fsw_pkg::BIT_LATCH]) |=> !o_array_go)
        else $error("go without latch");
    a_chip_erase_pl: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_array_req && i_array_chip_erase && st_reg.status[5:2] != 4'h0) |=> !o_array_go)
        else $error("erase in protect");
    a_quad_lock_off: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_quad_command_mode || st_reg.status[fsw_pkg::BIT_QPE]) |=> !o_hardware_lock_mode)
        else $error("lock in quad");
endmodule : fsw_status_core
`default_nettype wire

// [dv/fsw_host_model.sv]
// host-side serial flash controller model that frames commands
`default_nettype none
module fsw_host_model (
    // clock
    input wire logic i_clk,
    // mode and returned data lines
    input wire logic i_quad,
    input wire logic [3:0] i_sio,
    // link to the device
    output logic o_cs_n,
    output logic o_sclk_rise,
    output logic o_sclk_fall,
    output logic [3:0] o_sio
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_cs_n = 1'h1;
        o_sclk_rise = 1'h0;
        o_sclk_fall = 1'h0;
        o_sio = 4'h0;
    end
    // released lines toggle so no stale value passes for data
    always @(negedge i_clk) begin
        if (o_cs_n) begin
            o_sio <= ~o_sio;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic open_frame();
        @(negedge i_clk);
        o_cs_n = 1'h0;
        @(negedge i_clk);
    endtask : open_frame
    // one serial clock: take returned data, drive, rise, then fall
    task automatic clk_bit(input logic [3:0] v, output logic [3:0] r);
        r = i_sio;
        o_sio = v;
        o_sclk_rise = 1'h1;
        @(negedge i_clk);
        o_sclk_rise = 1'h0;
        o_sclk_fall = 1'h1;
        @(negedge i_clk);
        o_sclk_fall = 1'h0;
        repeat (2) @(negedge i_clk);
    endtask : clk_bit
    // one byte, msb first; quad sends high nibble first
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        logic [3:0] r;
        if (i_quad) begin
            clk_bit(d[7:4], r);
            q[7:4] = r;
            clk_bit(d[3:0], r);
            q[3:0] = r;
        end else begin
            for (int i = 7; i >= 0; i--) begin
                clk_bit({{3{~d[i]}}, d[i]}, r);
                q[i] = r[1];
            end
        end
    endtask : xfer
    task automatic close_frame();
        @(negedge i_clk);
        o_cs_n = 1'h1;
        repeat (3) @(negedge i_clk);
    endtask : close_frame
endmodule : fsw_host_model
`default_nettype wire

// [dv/flash_status_write_protect_tb.sv]
// self-checking bench of the flash status byte and write-protect core
`default_nettype none
module flash_status_write_protect_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, cs_n, sclk_rise, sclk_fall, wp, quad, oe_seen;
    logic areq, aerase, aprot, adone, ago, hwl;
    logic [3:0] hsio, dsio, doe_n, sio_w;
    logic [7:0] st, exp_st;
    logic [7:0] quad_ops [3];
    logic [31:0] rng;
    int n_errors, samples_checked;
    assign sio_w = (dsio & ~doe_n) | (hsio & doe_n);
    fsw_status_core fsw_status_core_i (
        .i_clk(clk), .i_rstn(rstn), .i_cs_n(cs_n), .i_sclk_rise(sclk_rise),
        .i_sclk_fall(sclk_fall), .i_sio(sio_w), .i_write_protect_pin(wp),
        .i_quad_command_mode(quad), .i_array_req(areq), .i_array_chip_erase(aerase),
        .i_array_protected(aprot), .i_array_done(adone), .o_array_go(ago), .o_sio(dsio),
        .o_sio_oe_n(doe_n), .o_flash_status_byte(st), .o_hardware_lock_mode(hwl)
    );
    fsw_host_model fsw_host_model_i (
        .i_clk(clk), .i_quad(quad), .i_sio(sio_w), .o_cs_n(cs_n),
        .o_sclk_rise(sclk_rise), .o_sclk_fall(sclk_fall), .o_sio(hsio)
    );
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    always @(negedge clk) begin
        if (doe_n !== 4'hF) oe_seen <= 1'h1;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic hw_lock_exp(input logic [7:0] s, input logic p, input logic q);
        return s[fsw_pkg::BIT_LOCK] && !p && !s[fsw_pkg::BIT_QPE] && !q;
    endfunction : hw_lock_exp
    function automatic logic write_ok(input logic [7:0] s, input logic p, input logic q);
        return s[fsw_pkg::BIT_LATCH] && !hw_lock_exp(s, p, q);
    endfunction : write_ok
    task automatic check(input logic [7:0] got, input logic [7:0] e, input string m);
        samples_checked++;
        if (got !== e) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, m, got, e);
        end
    endtask : check
    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////
    task automatic cmd(input logic [7:0] op);
        logic [7:0] q;
        fsw_host_model_i.open_frame();
        fsw_host_model_i.xfer(op, q);
        fsw_host_model_i.close_frame();
        if (op == fsw_pkg::OP_LATCH_SET) exp_st[1] = 1'h1;
        if (op == fsw_pkg::OP_LATCH_CLEAR) exp_st[1] = 1'h0;
    endtask : cmd
    task automatic rd(input logic [7:0] m, input logic [7:0] e);
        logic [7:0] q1, q2;
        fsw_host_model_i.open_frame();
        fsw_host_model_i.xfer(fsw_pkg::OP_STATUS_READ, q1);
        fsw_host_model_i.xfer(8'h00, q1);
        fsw_host_model_i.xfer(8'h00, q2);
        fsw_host_model_i.close_frame();
        check(q1 & m, e & m, "status read");
        check(q2 & m, e & m, "status repeat");
        check(doe_n, 4'hF, "released after frame");
    endtask : rd
    task automatic lockchk();
        repeat (3) @(negedge clk);
        check(hwl, hw_lock_exp(exp_st, wp, quad), "lock mode");
    endtask : lockchk
    // status write of nbits data bits; only 8 lands on a byte boundary
    task automatic wr(input logic [7:0] d, input int nbits);
        logic [7:0] q;
        logic [3:0] r;
        logic ok;
        time t0;
        int n;
        ok = write_ok(exp_st, wp, quad) && nbits == 8;
        fsw_host_model_i.open_frame();
        fsw_host_model_i.xfer(fsw_pkg::OP_STATUS_WRITE, q);
        for (int i = 0; i < nbits; i++) fsw_host_model_i.clk_bit({3'h0, d[7 - i]}, r);
        fsw_host_model_i.close_frame();
        if (ok) begin
            t0 = $time;
            rd(8'h01, 8'h01);
            while (st[fsw_pkg::BIT_BUSY] === 1'h1 && $time - t0 < 120000) @(negedge clk);
            n = int'(($time - t0) / 4) + 3;
            check(n >= fsw_pkg::STATUS_WRITE_CYCLES && n <= fsw_pkg::STATUS_WRITE_CYCLES + 6,
                1'h1, "write cycle length");
            exp_st = d & fsw_pkg::NV_WRITE_MASK;
        end else begin
            repeat (2) @(negedge clk);
            check(st[fsw_pkg::BIT_BUSY], 1'h0, "refused write busy");
        end
        rd(8'hFF, exp_st);
        lockchk();
    endtask : wr
    task automatic arr(input logic ce, input logic pr, input logic e);
        logic go;
        @(negedge clk);
        areq = 1'h1;
        aerase = ce;
        aprot = pr;
        @(negedge clk);
        areq = 1'h0;
        go = 1'h0;
        repeat (4) begin
            go |= ago;
            @(negedge clk);
        end
        check(go, e, "array go");
        if (go === 1'h1) begin
            check(st[fsw_pkg::BIT_BUSY], 1'h1, "array busy");
            adone = 1'h1;
            @(negedge clk);
            adone = 1'h0;
            repeat (3) @(negedge clk);
        end
        if (e || pr) exp_st[fsw_pkg::BIT_LATCH] = 1'h0;
        rd((ce && !e && !pr) ? 8'hFD : 8'hFF, exp_st);
    endtask : arr
    ////////////////////////////////////////////////////////////////////////////
    // whole run needs about 45000 cycles; cut off at 60000
    initial begin
        #240000;
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end
    initial begin
        rstn = 1'h0;
        wp = 1'h1;
        quad = 1'h0;
        areq = 1'h0;
        aerase = 1'h0;
        aprot = 1'h0;
        adone = 1'h0;
        oe_seen = 1'h0;
        n_errors = 0;
        samples_checked = 0;
        exp_st = fsw_pkg::STATUS_RESET;
        rng = 32'hD63F2E45;
        quad_ops = '{fsw_pkg::OP_QUAD_READ, fsw_pkg::OP_QUAD_WREAD, fsw_pkg::OP_QUAD_PROG};
        repeat (2) @(negedge clk);
        rstn = 1'h1;
        check(st, fsw_pkg::STATUS_RESET, "reset value");
        rd(8'hFF, exp_st);
        quad = 1'h1;
        rd(8'hFF, exp_st);
        quad = 1'h0;
        done("reset and read");
        rng = xs(rng);
        wr(rng[7:0], 8);
        cmd(fsw_pkg::OP_LATCH_SET);
        rd(8'hFF, exp_st);
        cmd(fsw_pkg::OP_LATCH_CLEAR);
        rd(8'hFF, exp_st);
        arr(1'h0, 1'h0, 1'h0);
        cmd(fsw_pkg::OP_LATCH_SET);
        wr(rng[15:8], 4);
        wr((rng[15:8] & 8'h3C) | 8'h04, 8);
        done("latch and write");
        cmd(fsw_pkg::OP_LATCH_SET);
        arr(1'h1, 1'h0, 1'h0);
        cmd(fsw_pkg::OP_LATCH_CLEAR);
        cmd(fsw_pkg::OP_LATCH_SET);
        arr(1'h0, 1'h1, 1'h0);
        cmd(fsw_pkg::OP_LATCH_SET);
        arr(1'h0, 1'h0, 1'h1);
        foreach (quad_ops[i]) begin
            oe_seen = 1'h0;
            cmd(quad_ops[i]);
            check(oe_seen, 1'h0, "quad opcode answered");
        end
        done("array and quad opcodes");
        wp = 1'h0;
        cmd(fsw_pkg::OP_LATCH_SET);
        rng = xs(rng);
        wr((rng[7:0] & 8'h3C) | 8'h80, 8);
        cmd(fsw_pkg::OP_LATCH_SET);
        wr(8'h00, 8);
        cmd(fsw_pkg::OP_LATCH_CLEAR);
        quad = 1'h1;
        lockchk();
        quad = 1'h0;
        lockchk();
        wp = 1'h1;
        lockchk();
        cmd(fsw_pkg::OP_LATCH_SET);
        wr(8'hC0, 8);
        wp = 1'h0;
        lockchk();
        cmd(fsw_pkg::OP_LATCH_SET);
        wr(8'h00, 8);
        cmd(fsw_pkg::OP_LATCH_SET);
        arr(1'h1, 1'h0, 1'h1);
        done("protection modes");
        finish_test();
    end
endmodule : flash_status_write_protect_tb
`default_nettype wire
